// file: hdl/smc_standby_ctrl.sv
// Standby mode controller: run, halt and stop states, clock and
// peripheral gating, wake logic and a small register port.
// Assumes standby requests are one-cycle pulses from the CPU.
//
// Functional notes
// - Stop entry only with main clock selected
// - Halt entry with main or subclock
// - Stop halts main oscillator, subclock keeps running
// - Halt gates CPU clock, not main oscillator
// - Interval timer stops in stop, runs in halt
// - Stop: serial runs only on external clock
// - Halt: serial runs unless clocked by CPU
// - Stop: event counter only on event pin
// - Stop: watch timer only on subclock
// - Display never runs in standby
// - Wake by reset or enabled operable interrupt other than external pins
// - Display only main clock, high/mid speed
// - Display on during clock change flags error
`timescale 1ns/1ps
module smc_standby_ctrl import smc_pkg::*; #(
  parameter int N_SRC = NUM_SRC
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [DATA_W-1:0]   wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [DATA_W-1:0]   rdata_out,
  input  wire logic                stop_req_in,
  input  wire logic                halt_req_in,
  input  wire logic [N_SRC-1:0]    irq_req_in,
  output logic                     main_osc_en_out,
  output logic                     sub_osc_en_out,
  output logic                     cpu_clk_en_out,
  output smc_periph_en_t           periph_en_out,
  output smc_mode_t                mode_out,
  output logic                     cpu_resume_out,
  output logic                     irq_out
);

  logic [3:0]        proc_clk_r,   proc_clk_nxt;
  logic              sys_clk_r,    sys_clk_nxt;
  logic [3:0]        display_r,    display_nxt;
  smc_clk_src_t      clk_src_r,    clk_src_nxt;
  logic [N_SRC-1:0]  wake_en_r,    wake_en_nxt;
  logic [NUM_ST-1:0] status_r,     status_nxt;
  logic [NUM_ST-1:0] mask_r,       mask_nxt;
  logic [DATA_W-1:0] rdata_r,      rdata_nxt;
  smc_mode_t         mode_r,       mode_nxt;
  logic              resume_r,     resume_nxt;
  smc_periph_en_t    periph_r,     periph_nxt;
  logic              main_osc_r,   main_osc_nxt;
  logic              cpu_clk_r,    cpu_clk_nxt;

  logic [N_SRC-1:0]  operable;
  logic              wake;
  logic [NUM_ST-1:0] events;
  logic              stop_ok;
  logic              enter;
  logic              clk_write;

  // Which interrupt sources still run in the current standby state
  always_comb begin
    operable = '1;
    if (mode_r == SMC_STOP) begin
      operable[SRC_INTERVAL] = 1'b0;
      operable[SRC_SERIAL]   = clk_src_r.sio_ext;
      operable[SRC_EVENT]    = clk_src_r.event_pin;
      operable[SRC_PULSE]    = 1'b0;
      operable[SRC_WATCH]    = clk_src_r.watch_subclk;
    end else if (mode_r == SMC_HALT) begin
      operable[SRC_SERIAL]   = ~clk_src_r.sio_cpu;
    end
  end

  smc_wake_gate #(
    .N_SRC    (N_SRC),
    .EXCL_SRC (EXT_SRC_MASK)
  ) u_wake (
    .req_in      (irq_req_in),
    .enable_in   (wake_en_r),
    .operable_in (operable),
    .wake_out    (wake)
  );

  // Register port
  always_comb begin
    proc_clk_nxt = proc_clk_r;
    sys_clk_nxt  = sys_clk_r;
    display_nxt  = display_r;
    clk_src_nxt  = clk_src_r;
    wake_en_nxt  = wake_en_r;
    mask_nxt     = mask_r;
    rdata_nxt    = '0;
    if (wr_in) begin
      unique case (addr_in)
        ADDR_PROC_CLK: proc_clk_nxt = wdata_in[3:0];
        ADDR_SYS_CLK:  sys_clk_nxt  = wdata_in[SYS_SUB_BIT];
        ADDR_DISPLAY:  display_nxt  = wdata_in[3:0];
        ADDR_CLK_SRC:  clk_src_nxt  = smc_clk_src_t'(wdata_in[3:0]);
        ADDR_WAKE_EN:  wake_en_nxt  = wdata_in[N_SRC-1:0];
        ADDR_MASK:     mask_nxt     = wdata_in[NUM_ST-1:0];
        default: ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        ADDR_PROC_CLK: rdata_nxt[3:0]        = proc_clk_r;
        ADDR_SYS_CLK:  rdata_nxt[0]          = sys_clk_r;
        ADDR_DISPLAY:  rdata_nxt[3:0]        = display_r;
        ADDR_CLK_SRC:  rdata_nxt[3:0]        = clk_src_r;
        ADDR_WAKE_EN:  rdata_nxt[N_SRC-1:0]  = wake_en_r;
        ADDR_STATUS:   rdata_nxt[NUM_ST-1:0] = status_r;
        ADDR_MASK:     rdata_nxt[NUM_ST-1:0] = mask_r;
        ADDR_STATE:    rdata_nxt[1:0]        = mode_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      proc_clk_r <= PROC_CLK_RST;
      sys_clk_r  <= SYS_CLK_RST;
      display_r  <= DISPLAY_RST;
      clk_src_r  <= CLK_SRC_RST;
      wake_en_r  <= WAKE_EN_RST;
      mask_r     <= MASK_RST;
      rdata_r    <= '0;
    end else begin
      proc_clk_r <= proc_clk_nxt;
      sys_clk_r  <= sys_clk_nxt;
      display_r  <= display_nxt;
      clk_src_r  <= clk_src_nxt;
      wake_en_r  <= wake_en_nxt;
      mask_r     <= mask_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Mode sequencing and gating
  always_comb begin
    stop_ok    = stop_req_in & ~sys_clk_r;
    enter      = 1'b0;
    mode_nxt   = mode_r;
    resume_nxt = 1'b0;
    events     = '0;
    clk_write  = wr_in & ((addr_in == ADDR_PROC_CLK) | (addr_in == ADDR_SYS_CLK));
    unique case (mode_r)
      SMC_RUN: begin
        // Stop wins over a simultaneous halt request
        if (stop_ok) begin
          mode_nxt = SMC_STOP;
          enter    = 1'b1;
        end else if (halt_req_in) begin
          mode_nxt = SMC_HALT;
          enter    = 1'b1;
        end
        events[ST_REFUSED] = stop_req_in & sys_clk_r;
      end
      SMC_HALT, SMC_STOP: begin
        if (wake) begin
          mode_nxt         = SMC_RUN;
          resume_nxt       = 1'b1;
          events[ST_WOKE]  = 1'b1;
        end
      end
      default: mode_nxt = SMC_RUN;
    endcase
    events[ST_DSP_VIOL] = display_r[DSP_ON_BIT] & (enter | clk_write);

    main_osc_nxt = (mode_nxt != SMC_STOP);
    cpu_clk_nxt  = (mode_nxt == SMC_RUN);
    periph_nxt   = '1;
    unique case (mode_nxt)
      SMC_STOP: begin
        periph_nxt.bit_timer = 1'b0;
        periph_nxt.serial    = clk_src_nxt.sio_ext;
        periph_nxt.event_cnt = clk_src_nxt.event_pin;
        periph_nxt.pulse_gen = 1'b0;
        periph_nxt.watch     = clk_src_nxt.watch_subclk;
      end
      SMC_HALT: periph_nxt.serial = ~clk_src_nxt.sio_cpu;
      default: ;
    endcase
    // Gated rather than trusted to software: a wrong clock corrupts the scan
    periph_nxt.display = display_nxt[DSP_ON_BIT] & (mode_nxt == SMC_RUN)
                       & ~sys_clk_nxt
                       & ((proc_clk_nxt == PROC_CLK_HIGH) | (proc_clk_nxt == PROC_CLK_MID));
    // Set wins over a same-cycle write-one clear
    status_nxt = status_r;
    if (wr_in && addr_in == ADDR_STATUS) begin
      status_nxt = status_r & ~wdata_in[NUM_ST-1:0];
    end
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r     <= SMC_RUN;
      resume_r   <= 1'b0;
      main_osc_r <= 1'b1;
      cpu_clk_r  <= 1'b1;
      periph_r   <= '0;
      status_r   <= STATUS_RST;
    end else begin
      mode_r     <= mode_nxt;
      resume_r   <= resume_nxt;
      main_osc_r <= main_osc_nxt;
      cpu_clk_r  <= cpu_clk_nxt;
      periph_r   <= periph_nxt;
      status_r   <= status_nxt;
    end
  end

  assign rdata_out       = rdata_r;
  assign main_osc_en_out = main_osc_r;
  assign sub_osc_en_out  = 1'b1;
  assign cpu_clk_en_out  = cpu_clk_r;
  assign periph_en_out   = periph_r;
  assign mode_out        = mode_r;
  assign cpu_resume_out  = resume_r;
  assign irq_out         = |(status_r & mask_r);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence run_stop_refused_s;
    mode_r == SMC_RUN && stop_req_in && sys_clk_r;
  endsequence

  sequence standby_wake_s;
    mode_r != SMC_RUN && wake;
  endsequence

  sequence resumed_s;
    mode_r == SMC_RUN && cpu_clk_en_out && cpu_resume_out;
  endsequence

  sequence run_stop_taken_s;
    mode_r == SMC_RUN && stop_req_in && !sys_clk_r;
  endsequence

  stop_refused_a: assert property (run_stop_refused_s |=> mode_r != SMC_STOP
                                   && status_r[ST_REFUSED])
    else $error("stop entered with subclock selected");
  halt_entry_a: assert property (mode_r == SMC_RUN && halt_req_in && !stop_ok
                                 |=> mode_r == SMC_HALT && !cpu_clk_en_out)
    else $error("halt request not taken");
  stop_osc_a: assert property (mode_r == SMC_STOP |->
                               !main_osc_en_out && sub_osc_en_out)
    else $error("stop oscillator gating wrong");
  halt_clock_a: assert property (mode_r == SMC_HALT |->
                                 main_osc_en_out && !cpu_clk_en_out)
    else $error("halt clock gating wrong");
  interval_timer_a: assert property (mode_r != SMC_RUN |->
                                     periph_en_out.bit_timer == (mode_r == SMC_HALT))
    else $error("interval timer gating wrong");
  serial_stop_a: assert property (mode_r == SMC_STOP |->
                                  periph_en_out.serial == clk_src_r.sio_ext)
    else $error("serial gating in stop wrong");
  serial_halt_a: assert property (mode_r == SMC_HALT |->
                                  periph_en_out.serial == !clk_src_r.sio_cpu)
    else $error("serial gating in halt wrong");
  event_count_a: assert property (mode_r == SMC_STOP |->
                                  periph_en_out.event_cnt == clk_src_r.event_pin)
    else $error("event counter gating wrong");
  watch_timer_a: assert property (mode_r == SMC_STOP |->
                                  periph_en_out.watch == clk_src_r.watch_subclk)
    else $error("watch timer gating wrong");
  display_standby_a: assert property (mode_r != SMC_RUN |->
                                      !periph_en_out.display)
    else $error("display running in standby");
  wake_release_a: assert property (standby_wake_s |=> resumed_s)
    else $error("enabled wake did not release standby");
  ext_no_wake_a: assert property (mode_r != SMC_RUN
                                  && (irq_req_in & ~EXT_SRC_MASK) == '0 |=> $stable(mode_r))
    else $error("external pin released standby");
  display_clock_a: assert property (periph_en_out.display |->
                                    !sys_clk_r && (proc_clk_r == PROC_CLK_HIGH
                                    || proc_clk_r == PROC_CLK_MID))
    else $error("display running on wrong clock");
  display_viol_a: assert property (mode_r == SMC_RUN && clk_write
                                   && display_r[DSP_ON_BIT] |=> status_r[ST_DSP_VIOL])
    else $error("clock change with display on not flagged");
  // A halt may follow in the very next cycle, so clock is checked in the pulse cycle
  resume_pulse_a: assert property (cpu_resume_out |-> cpu_clk_en_out
                                   ##1 !cpu_resume_out)
    else $error("resume pulse longer than one cycle");
  stop_entry_a: assert property (run_stop_taken_s |=> mode_r == SMC_STOP
                                 && !main_osc_en_out && !cpu_clk_en_out)
    else $error("stop request with main clock not taken");
  woke_flag_a: assert property (standby_wake_s |=>
                                status_r[ST_WOKE])
    else $error("wake not recorded in status");
  entry_viol_a: assert property (mode_r == SMC_RUN && enter
                                 && display_r[DSP_ON_BIT] |=> status_r[ST_DSP_VIOL])
    else $error("standby entry with display on not flagged");
  standby_hold_a: assert property (mode_r != SMC_RUN && !wake |=>
                                   $stable(mode_r))
    else $error("standby left without wake");

endmodule : smc_standby_ctrl

// file: inc/smc_pkg.sv
// Constants and carrier types for the standby mode controller.
// Assumes a single 200 MHz system clock and an 8-bit register port.
package smc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_SRC = 8;
  localparam int NUM_ST = 3;

  // Register offsets
  localparam logic [7:0] ADDR_PROC_CLK = 8'h00;
  localparam logic [7:0] ADDR_SYS_CLK  = 8'h01;
  localparam logic [7:0] ADDR_DISPLAY  = 8'h02;
  localparam logic [7:0] ADDR_CLK_SRC  = 8'h03;
  localparam logic [7:0] ADDR_WAKE_EN  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h05;
  localparam logic [7:0] ADDR_MASK     = 8'h06;
  localparam logic [7:0] ADDR_STATE    = 8'h07;

  // Reset values
  localparam logic [3:0] PROC_CLK_RST = 4'h0;
  localparam logic       SYS_CLK_RST  = 1'b0;
  localparam logic [3:0] DISPLAY_RST  = 4'h0;
  localparam logic [3:0] CLK_SRC_RST  = 4'h0;
  localparam logic [7:0] WAKE_EN_RST  = 8'h00;
  localparam logic [2:0] STATUS_RST   = 3'h0;
  localparam logic [2:0] MASK_RST     = 3'h0;

  // Field positions and codes
  localparam int         SYS_SUB_BIT    = 0;
  localparam int         DSP_ON_BIT     = 3;
  localparam logic [3:0] PROC_CLK_HIGH  = 4'h3;
  localparam logic [3:0] PROC_CLK_MID   = 4'h2;
  localparam int         ST_REFUSED     = 0;
  localparam int         ST_DSP_VIOL    = 1;
  localparam int         ST_WOKE        = 2;

  // Wake source indices
  localparam int SRC_INTERVAL = 0;
  localparam int SRC_SERIAL   = 1;
  localparam int SRC_EVENT    = 2;
  localparam int SRC_PULSE    = 3;
  localparam int SRC_WATCH    = 4;
  localparam logic [NUM_SRC-1:0] EXT_SRC_MASK = 8'he0;

  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_HALT,
    SMC_STOP
  } smc_mode_t;

  typedef struct packed {
    logic watch_subclk;
    logic event_pin;
    logic sio_cpu;
    logic sio_ext;
  } smc_clk_src_t;

  typedef struct packed {
    logic display;
    logic watch;
    logic pulse_gen;
    logic event_cnt;
    logic serial;
    logic bit_timer;
  } smc_periph_en_t;

endpackage : smc_pkg

// file: hdl/smc_wake_gate.sv
// Wake qualifier: one lane per interrupt source.
// Assumes requests, enables and operable flags are synchronous levels.
`timescale 1ns/1ps
module smc_wake_gate import smc_pkg::*; #(
  parameter int                 N_SRC    = NUM_SRC,
  parameter logic [N_SRC-1:0]   EXCL_SRC = EXT_SRC_MASK
) (
  input  wire logic [N_SRC-1:0] req_in,
  input  wire logic [N_SRC-1:0] enable_in,
  input  wire logic [N_SRC-1:0] operable_in,
  output logic                  wake_out
);

  logic [N_SRC-1:0] lane;

  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_lane
      // External pins never release standby
      assign lane[g] = req_in[g] & enable_in[g] & operable_in[g] & ~EXCL_SRC[g];
    end
  endgenerate

  assign wake_out = |lane;

endmodule : smc_wake_gate

// file: sim/tb_smc_standby_ctrl.sv
// Self-checking bench for the standby mode controller.
// Assumes the register map and wake lanes of smc_pkg; no partner model.
`timescale 1ns/1ps
module tb_smc_standby_ctrl import smc_pkg::*; ();
  logic           clk_sys  = 1'b0;
  logic           rst_n    = 1'b0;
  logic [7:0]     addr     = 8'h00;
  logic [7:0]     wdata    = 8'h00;
  logic           wr       = 1'b0;
  logic           rd       = 1'b0;
  logic           stop_req = 1'b0;
  logic           halt_req = 1'b0;
  logic [7:0]     irq_req  = 8'h00;
  logic [7:0]     rdata;
  logic           main_osc;
  logic           sub_osc;
  logic           cpu_clk;
  logic           resume;
  logic           irq;
  smc_periph_en_t periph;
  smc_mode_t      mode;
  int             err_total = 0;
  int             tests_run = 0;

  always #2.5 clk_sys = ~clk_sys;

  smc_standby_ctrl i_dut (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .stop_req_in(stop_req),
    .halt_req_in(halt_req), .irq_req_in(irq_req), .main_osc_en_out(main_osc),
    .sub_osc_en_out(sub_osc), .cpu_clk_en_out(cpu_clk), .periph_en_out(periph),
    .mode_out(mode), .cpu_resume_out(resume), .irq_out(irq));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask : rd_chk

  // Standby request pulse; returns just after the edge that takes it
  task automatic pulse(input logic stop);
    @(posedge clk_sys);
    if (stop) stop_req <= 1'b1;
    else halt_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    halt_req <= 1'b0;
    #1;
  endtask : pulse

  // Levels held for n edges, so a wake shows after one
  task automatic raise(input logic [7:0] r, input int n);
    @(posedge clk_sys);
    irq_req <= r;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : raise

  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd_chk("reg reset", 8'(i), 8'h00);
    rd_chk("unmapped", 8'h3c, 8'h00);
    chk("run clocks", 8'h07, {5'h0, main_osc, sub_osc, cpu_clk});
    $display("Test reset done");
  endtask : t_reset

  task automatic t_stop();
    wr_reg(ADDR_WAKE_EN, 8'hff);
    pulse(1'b1);
    chk("stop mode", 8'h02, {6'h0, mode});
    chk("stop osc", 8'h01, {6'h0, main_osc, sub_osc});
    chk("stop cpu", 8'h00, {7'h0, cpu_clk});
    chk("stop periph", 8'h00, {2'h0, periph});
    raise(8'h1f, 3);
    chk("no wake", 8'h02, {6'h0, mode});
    raise(8'h00, 1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("reset wake", 8'h00, {6'h0, mode});
    wr_reg(ADDR_WAKE_EN, 8'hff);
    wr_reg(ADDR_CLK_SRC, 8'h0d);
    pulse(1'b1);
    chk("stop periph src", 8'h16, {2'h0, periph});
    raise(8'h01, 3);
    chk("timer stopped", 8'h02, {6'h0, mode});
    raise(8'he0, 3);
    chk("pins no wake", 8'h02, {6'h0, mode});
    raise(8'h10, 1);
    chk("watch wake", 8'h00, {6'h0, mode});
    chk("resume", 8'h03, {6'h0, resume, cpu_clk});
    raise(8'h00, 1);
    $display("Test stop done");
  endtask : t_stop

  task automatic t_halt();
    wr_reg(ADDR_SYS_CLK, 8'h01);
    pulse(1'b1);
    chk("stop refused", 8'h00, {6'h0, mode});
    rd_chk("refuse flag", ADDR_STATUS, 8'h05);
    wr_reg(ADDR_MASK, 8'h01);
    @(posedge clk_sys);
    #1;
    chk("irq set", 8'h01, {7'h0, irq});
    wr_reg(ADDR_STATUS, 8'h07);
    @(posedge clk_sys);
    #1;
    chk("irq clear", 8'h00, {7'h0, irq});
    wr_reg(ADDR_CLK_SRC, 8'h02);
    pulse(1'b0);
    chk("halt mode", 8'h01, {6'h0, mode});
    chk("halt clocks", 8'h06, {5'h0, main_osc, sub_osc, cpu_clk});
    chk("halt periph", 8'h1d, {2'h0, periph});
    rd_chk("state halt", ADDR_STATE, 8'h01);
    raise(8'h02, 3);
    chk("serial on cpu", 8'h01, {6'h0, mode});
    raise(8'h08, 1);
    chk("pulse wake", 8'h00, {6'h0, mode});
    chk("halt resume", 8'h03, {6'h0, resume, cpu_clk});
    raise(8'h00, 1);
    wr_reg(ADDR_SYS_CLK, 8'h00);
    wr_reg(ADDR_MASK, 8'h00);
    $display("Test halt done");
  endtask : t_halt

  task automatic t_display();
    wr_reg(ADDR_DISPLAY, 8'h08);
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_PROC_CLK, 8'(c));
      @(posedge clk_sys);
      #1;
      chk("display speed", 8'(c >= 2), {7'h0, periph.display});
    end
    rd_chk("clock change flag", ADDR_STATUS, 8'h06);
    wr_reg(ADDR_SYS_CLK, 8'h01);
    @(posedge clk_sys);
    #1;
    chk("display subclk", 8'h00, {7'h0, periph.display});
    wr_reg(ADDR_SYS_CLK, 8'h00);
    wr_reg(ADDR_STATUS, 8'h07);
    pulse(1'b0);
    chk("display standby", 8'h00, {7'h0, periph.display});
    rd_chk("standby flag", ADDR_STATUS, 8'h02);
    raise(8'h01, 1);
    chk("timer wake", 8'h00, {6'h0, mode});
    raise(8'h00, 1);
    $display("Test display done");
  endtask : t_display

  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_stop();
    t_halt();
    t_display();
    results();
  end

  // Whole run needs about 120 cycles; this is over thirty times that
  initial begin
    repeat (4000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule : tb_smc_standby_ctrl
